/* File: sscr_pkg.sv */
package sscr_pkg;

  localparam logic [11:0] SSCR_STATUS_OFS = 12'h0a0;
  localparam logic [11:0] SSCR_CONTROL_OFS = 12'h0a4;

  localparam int SSCR_ST_LREV_BIT = 9;
  localparam int SSCR_ST_REFCLK_BIT = 10;
  localparam int SSCR_ST_HOLD_BIT = 11;
  localparam int SSCR_ST_MARKER_LSB = 13;
  localparam int SSCR_ST_MARKER_W = 4;
  localparam int SSCR_ST_INT_LSB = 20;
  localparam int SSCR_ST_INT_W = 4;

  localparam int SSCR_CT_RST_BIT = 0;
  localparam int SSCR_CT_HOLD_BIT = 1;
  localparam int SSCR_CT_UNLOCK_BIT = 2;
  localparam int SSCR_CT_STRICT_BIT = 3;

  localparam logic [3:0] SSCR_MARKER_RST = 4'h0;
  localparam logic SSCR_UNLOCK_RST = 1'b0;
  localparam logic SSCR_STRICT_RST = 1'b0;

  localparam int SSCR_CLK_PERIOD_NS = 8;
  localparam int SSCR_RST_OP_NS = 80;
  localparam int SSCR_RST_OP_CYC = (SSCR_RST_OP_NS + SSCR_CLK_PERIOD_NS - 1) / SSCR_CLK_PERIOD_NS;
  localparam logic [3:0] SSCR_RST_OP_LAST = 4'(SSCR_RST_OP_CYC - 1);

  typedef enum logic [1:0] {
    SSCR_IN_RESET,
    SSCR_IN_HOLD,
    SSCR_RUNNING
  } sscr_phase_t;

  // Strap order: [0] lane reverse, [1] refclk mode, [2] reset hold
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sscr_req_t;

  typedef struct packed {
    logic [2:0] strapS1;
    logic [2:0] strapS2;
    logic [2:0] strapS3;
    logic [2:0] strapLatched;
    logic [3:0] marker;
    logic holdBit;
    logic unlock;
    logic strictOrd;
    logic fundOp;
    sscr_phase_t phase;
    logic [3:0] cnt;
    logic coreHold;
    logic rdValid;
    logic [31:0] rdData;
  } sscr_state_t;

endpackage : sscr_pkg

/* File: switch_status_control_regs.sv */
`timescale 1ns/1ns
module switch_status_control_regs import sscr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire sscr_req_t regReq,
  input wire logic hotResetReq,
  input wire logic eepromHoldLoad,
  input wire logic [2:0] strapPins,
  input wire logic [3:0] intState,
  output logic [31:0] regRdData,
  output logic regRdValid,
  output logic coreResetHold,
  output logic lockableWriteEnable,
  output logic strictOrderingForce
);

  sscr_state_t s_q;
  sscr_state_t s_d;

  logic strapStable;
  logic ctlWrite;
  logic staWrite;

  always_comb begin
    strapStable = (s_q.strapS2 == s_q.strapS3);
    ctlWrite = regReq.wr && (regReq.addr == SSCR_CONTROL_OFS);
    staWrite = regReq.wr && (regReq.addr == SSCR_STATUS_OFS);
    s_d = s_q;
    s_d.strapS1 = strapPins;
    s_d.strapS2 = s_q.strapS1;
    s_d.strapS3 = s_q.strapS2;
    s_d.rdValid = regReq.rd;
    s_d.rdData = 32'h0;
    if (staWrite) begin
      s_d.marker = regReq.wdata[SSCR_ST_MARKER_LSB +: SSCR_ST_MARKER_W];
    end
    if (ctlWrite) begin
      s_d.unlock = regReq.wdata[SSCR_CT_UNLOCK_BIT];
      s_d.strictOrd = regReq.wdata[SSCR_CT_STRICT_BIT];
      if (s_q.phase != SSCR_RUNNING) begin
        s_d.holdBit = regReq.wdata[SSCR_CT_HOLD_BIT];
      end
    end
    // Load during reset or hold wins over a clearing write, and is seen by the phase decision below
    if (eepromHoldLoad && s_q.phase != SSCR_RUNNING) begin
      s_d.holdBit = 1'b1;
    end
    case (s_q.phase)
      SSCR_IN_RESET: begin
        s_d.unlock = 1'b1;
        s_d.cnt = s_q.cnt + 4'h1;
        if (strapStable && s_q.fundOp) begin
          s_d.strapLatched = s_q.strapS3;
        end
        if (strapStable && s_q.strapS3[2]) begin
          s_d.holdBit = 1'b1;
        end
        if (s_q.cnt == SSCR_RST_OP_LAST) begin
          s_d.cnt = 4'h0;
          s_d.phase = s_d.holdBit ? SSCR_IN_HOLD : SSCR_RUNNING;
        end
      end
      SSCR_IN_HOLD: begin
        if (!s_d.holdBit) begin
          s_d.phase = SSCR_RUNNING;
        end
      end
      SSCR_RUNNING: begin
        s_d.cnt = 4'h0;
      end
      default: begin
        s_d.phase = SSCR_IN_RESET;
      end
    endcase
    if (ctlWrite && regReq.wdata[SSCR_CT_RST_BIT]) begin
      s_d.phase = SSCR_IN_RESET;
      s_d.fundOp = 1'b1;
      s_d.cnt = 4'h0;
      s_d.holdBit = 1'b0;
      s_d.marker = SSCR_MARKER_RST;
      s_d.strictOrd = SSCR_STRICT_RST;
    end else if (hotResetReq) begin
      // Marker survives a hot reset
      s_d.phase = SSCR_IN_RESET;
      s_d.fundOp = 1'b0;
      s_d.cnt = 4'h0;
      s_d.holdBit = 1'b0;
      s_d.strictOrd = SSCR_STRICT_RST;
    end
    s_d.coreHold = (s_d.phase != SSCR_RUNNING);
    if (regReq.rd) begin
      if (regReq.addr == SSCR_STATUS_OFS) begin
        s_d.rdData[SSCR_ST_LREV_BIT] = s_q.strapLatched[0];
        s_d.rdData[SSCR_ST_REFCLK_BIT] = s_q.strapLatched[1];
        s_d.rdData[SSCR_ST_HOLD_BIT] = s_q.strapLatched[2];
        s_d.rdData[SSCR_ST_MARKER_LSB +: SSCR_ST_MARKER_W] = s_q.marker;
        s_d.rdData[SSCR_ST_INT_LSB +: SSCR_ST_INT_W] = intState;
      end else if (regReq.addr == SSCR_CONTROL_OFS) begin
        s_d.rdData[SSCR_CT_HOLD_BIT] = s_q.holdBit;
        s_d.rdData[SSCR_CT_UNLOCK_BIT] = s_q.unlock;
        s_d.rdData[SSCR_CT_STRICT_BIT] = s_q.strictOrd;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{strapS1: 3'h0, strapS2: 3'h0, strapS3: 3'h0, strapLatched: 3'h0,
               marker: SSCR_MARKER_RST, holdBit: 1'b0, unlock: SSCR_UNLOCK_RST,
               strictOrd: SSCR_STRICT_RST, fundOp: 1'b1, phase: SSCR_IN_RESET,
               cnt: 4'h0, coreHold: 1'b1, rdValid: 1'b0, rdData: 32'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign regRdValid = s_q.rdValid;
  assign coreResetHold = s_q.coreHold;
  assign lockableWriteEnable = s_q.unlock;
  assign strictOrderingForce = s_q.strictOrd;

  a_rst_bit_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(regReq.rd) |-> regRdData[SSCR_CT_RST_BIT] == 1'b0)
    else $error("control reset bit read back as one");

  a_reset_starts: assert property (@(posedge clk) disable iff (!rst_n)
    ctlWrite && regReq.wdata[SSCR_CT_RST_BIT] |=> s_q.phase == SSCR_IN_RESET && coreResetHold)
    else $error("written reset bit did not start a reset");

  a_hold_keeps_core: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_HOLD && s_q.holdBit && !ctlWrite |=> coreResetHold)
    else $error("core released while hold bit set");

  a_hold_locked_run: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_RUNNING && !hotResetReq && !(ctlWrite && regReq.wdata[SSCR_CT_RST_BIT])
    |=> s_q.holdBit == $past(s_q.holdBit))
    else $error("hold bit changed while running");

  a_strap_sets_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_RESET && strapStable && s_q.strapS3[2] && !ctlWrite && !hotResetReq
    |=> s_q.holdBit)
    else $error("hold strap did not set hold bit");

  a_unlock_in_reset: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_RESET ##1 s_q.phase == SSCR_IN_RESET |-> lockableWriteEnable)
    else $error("unlock not set during reset operation");

  a_strict_follows: assert property (@(posedge clk) disable iff (!rst_n)
    ctlWrite && !regReq.wdata[SSCR_CT_RST_BIT] && !hotResetReq
    |=> strictOrderingForce == $past(regReq.wdata[SSCR_CT_STRICT_BIT]))
    else $error("strict ordering bit not written");

  a_marker_hot_keep: assert property (@(posedge clk) disable iff (!rst_n)
    hotResetReq && !regReq.wr |=> s_q.marker == $past(s_q.marker))
    else $error("hot reset changed marker");

  a_int_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == SSCR_STATUS_OFS
    |=> regRdData[SSCR_ST_INT_LSB +: SSCR_ST_INT_W] == $past(intState))
    else $error("interrupt state not reported");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(regReq.rd) |-> regRdData[31:24] == 8'h0 && regRdData[19:17] == 3'h0 && !regRdData[12])
    else $error("reserved status bits not zero");

  a_lrev_readout: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == SSCR_STATUS_OFS
    |=> regRdData[SSCR_ST_LREV_BIT] == $past(s_q.strapLatched[0]))
    else $error("lane reverse strap not reported");

  a_refclk_readout: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == SSCR_STATUS_OFS
    |=> regRdData[SSCR_ST_REFCLK_BIT] == $past(s_q.strapLatched[1]))
    else $error("refclk mode strap not reported");

  a_hold_strap_read: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == SSCR_STATUS_OFS
    |=> regRdData[SSCR_ST_HOLD_BIT] == $past(s_q.strapLatched[2]))
    else $error("reset hold strap not reported");

  a_marker_readout: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == SSCR_STATUS_OFS
    |=> regRdData[SSCR_ST_MARKER_LSB +: SSCR_ST_MARKER_W] == $past(s_q.marker))
    else $error("marker not reported");

  a_marker_write: assert property (@(posedge clk) disable iff (!rst_n)
    staWrite
    |=> s_q.marker == $past(regReq.wdata[SSCR_ST_MARKER_LSB +: SSCR_ST_MARKER_W]))
    else $error("marker write not taken");

  a_hot_no_relatch: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_RESET && !s_q.fundOp
    |=> s_q.strapLatched == $past(s_q.strapLatched))
    else $error("straps relatched in hot reset");

  a_latch_outside: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase != SSCR_IN_RESET
    |=> s_q.strapLatched == $past(s_q.strapLatched))
    else $error("straps changed outside reset");

  a_rst_no_effect: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_RUNNING && ctlWrite && !regReq.wdata[SSCR_CT_RST_BIT] && !hotResetReq
    |=> s_q.phase == SSCR_RUNNING)
    else $error("written zero reset bit had an effect");

  a_fund_clears_marker: assert property (@(posedge clk) disable iff (!rst_n)
    ctlWrite && regReq.wdata[SSCR_CT_RST_BIT]
    |=> s_q.marker == SSCR_MARKER_RST && s_q.fundOp)
    else $error("fundamental reset kept marker");

  a_reset_length: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_RESET && s_q.cnt != SSCR_RST_OP_LAST
    |=> s_q.phase == SSCR_IN_RESET && coreResetHold)
    else $error("reset operation ended early");

  a_reset_ends: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_RESET && s_q.cnt == SSCR_RST_OP_LAST && !s_q.holdBit && !ctlWrite
    && !hotResetReq && !eepromHoldLoad && !(strapStable && s_q.strapS3[2])
    |=> s_q.phase == SSCR_RUNNING && !coreResetHold)
    else $error("switch logic not released after reset");

  a_hold_enters: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_RESET && s_q.cnt == SSCR_RST_OP_LAST && s_q.holdBit
    && !ctlWrite && !hotResetReq
    |=> s_q.phase == SSCR_IN_HOLD)
    else $error("hold phase not entered");

  a_hold_release: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_HOLD && ctlWrite && !regReq.wdata[SSCR_CT_HOLD_BIT]
    && !regReq.wdata[SSCR_CT_RST_BIT] && !eepromHoldLoad && !hotResetReq
    |=> s_q.phase == SSCR_RUNNING && !coreResetHold)
    else $error("clearing hold bit did not resume");

  a_hold_phase_bit: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_IN_HOLD
    |-> s_q.holdBit && coreResetHold)
    else $error("hold phase without hold bit");

  a_eeprom_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.phase == SSCR_RUNNING && eepromHoldLoad
    |=> s_q.holdBit == $past(s_q.holdBit))
    else $error("hold bit loaded while running");

  a_eeprom_sets_hold: assert property (@(posedge clk) disable iff (!rst_n)
    eepromHoldLoad && s_q.phase != SSCR_RUNNING && !hotResetReq
    && !(ctlWrite && regReq.wdata[SSCR_CT_RST_BIT])
    |=> s_q.holdBit)
    else $error("eeprom load did not set hold bit");

  a_unlock_write: assert property (@(posedge clk) disable iff (!rst_n)
    ctlWrite && s_q.phase != SSCR_IN_RESET && !regReq.wdata[SSCR_CT_RST_BIT]
    && !hotResetReq
    |=> lockableWriteEnable == $past(regReq.wdata[SSCR_CT_UNLOCK_BIT]))
    else $error("unlock bit not written");

  a_unlock_steady: assert property (@(posedge clk) disable iff (!rst_n)
    !ctlWrite && s_q.phase != SSCR_IN_RESET
    |=> lockableWriteEnable == $past(lockableWriteEnable))
    else $error("unlock bit changed without write");

  a_strict_steady: assert property (@(posedge clk) disable iff (!rst_n)
    !ctlWrite && !hotResetReq
    |=> strictOrderingForce == $past(strictOrderingForce))
    else $error("strict ordering changed without write");

  a_reset_clears_strict: assert property (@(posedge clk) disable iff (!rst_n)
    hotResetReq || (ctlWrite && regReq.wdata[SSCR_CT_RST_BIT])
    |=> !strictOrderingForce && !s_q.holdBit && s_q.cnt == 4'h0)
    else $error("reset entry did not clear controls");

  a_idle_data_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !regReq.rd
    |=> regRdData == 32'h0 && !regRdValid)
    else $error("read data not zero when idle");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr != SSCR_STATUS_OFS && regReq.addr != SSCR_CONTROL_OFS
    |=> regRdData == 32'h0)
    else $error("unmapped read not zero");

  a_ctl_readout: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == SSCR_CONTROL_OFS
    |=> regRdData[SSCR_CT_UNLOCK_BIT] == $past(lockableWriteEnable) && regRdData[SSCR_CT_STRICT_BIT] == $past(strictOrderingForce))
    else $error("control bits not reported");

  a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd
    |=> regRdValid)
    else $error("read not answered");

  a_hold_bit_read: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == SSCR_CONTROL_OFS
    |=> regRdData[SSCR_CT_HOLD_BIT] == $past(s_q.holdBit))
    else $error("hold bit not reported");

endmodule : switch_status_control_regs

/* File: switch_status_control_regs_test.sv */
`timescale 1ns/1ns
module switch_status_control_regs_test;
  import sscr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sscr_req_t regReq = '0;
  logic hotResetReq = 1'b0;
  logic eepromHoldLoad = 1'b0;
  logic [2:0] strapPins = 3'h3;
  logic [3:0] intState = 4'ha;
  logic [31:0] regRdData;
  logic regRdValid, coreResetHold, lockableWriteEnable, strictOrderingForce;
  int err_total = 0;
  int n_compared = 0;
  int n;
  logic [31:0] rdv;
  always #4 clk = ~clk;
  switch_status_control_regs switch_status_control_regs_inst (.clk(clk), .rst_n(rst_n), .regReq(regReq),
    .hotResetReq(hotResetReq), .eepromHoldLoad(eepromHoldLoad), .strapPins(strapPins), .intState(intState),
    .regRdData(regRdData), .regRdValid(regRdValid), .coreResetHold(coreResetHold),
    .lockableWriteEnable(lockableWriteEnable), .strictOrderingForce(strictOrderingForce));
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq <= '0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    regReq <= '0;
    #1;
    chk1(regRdValid, 1'b1);
    d = regRdData;
  endtask : rd
  // Counts edges after the trigger until switch logic leaves reset
  task automatic waitRun(output int cyc);
    for (cyc = 1; cyc <= 40; cyc++) begin
      @(posedge clk);
      #1;
      if (coreResetHold === 1'b0) break;
    end
    if (cyc > 40) begin
      err_total++;
      $display("[FAIL] %0t reset operation never ended", $time);
      end_sim();
    end
  endtask : waitRun
  task automatic powerUp();
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    waitRun(n);
    chk32(n, SSCR_RST_OP_CYC);
    chk1(lockableWriteEnable, 1'b1);
    chk1(strictOrderingForce, 1'b0);
    rd(SSCR_STATUS_OFS, rdv);
    chk32(rdv, 32'h00a00600);
  endtask : powerUp
  task automatic statusWrite();
    wr(SSCR_STATUS_OFS, 32'hffffffff);
    intState <= 4'h5;
    repeat (2) @(posedge clk);
    rd(SSCR_STATUS_OFS, rdv);
    chk32(rdv, 32'h0051e600);
    rd(12'h0a8, rdv);
    chk32(rdv, 32'h0);
  endtask : statusWrite
  task automatic controlWrite();
    wr(SSCR_CONTROL_OFS, 32'h0000000a);
    rd(SSCR_CONTROL_OFS, rdv);
    chk32(rdv, 32'h00000008);
    chk1(strictOrderingForce, 1'b1);
    chk1(lockableWriteEnable, 1'b0);
    chk1(coreResetHold, 1'b0);
  endtask : controlWrite
  task automatic hotWithLoad();
    @(posedge clk);
    strapPins <= 3'h0;
    eepromHoldLoad <= 1'b1;
    repeat (4) @(posedge clk);
    hotResetReq <= 1'b1;
    @(posedge clk);
    hotResetReq <= 1'b0;
    repeat (20) @(posedge clk);
    eepromHoldLoad <= 1'b0;
    #1;
    chk1(coreResetHold, 1'b1);
    chk1(lockableWriteEnable, 1'b1);
    chk1(strictOrderingForce, 1'b0);
    rd(SSCR_STATUS_OFS, rdv);
    chk32(rdv, 32'h0051e600);
    wr(SSCR_CONTROL_OFS, 32'h00000004);
    waitRun(n);
  endtask : hotWithLoad
  task automatic fundWithStrap();
    @(posedge clk);
    strapPins <= 3'h5;
    wr(SSCR_CONTROL_OFS, 32'h00000001);
    repeat (20) @(posedge clk);
    strapPins <= 3'h1;
    #1;
    chk1(coreResetHold, 1'b1);
    wr(SSCR_CONTROL_OFS, 32'h00000004);
    waitRun(n);
    rd(SSCR_STATUS_OFS, rdv);
    chk32(rdv, 32'h00500a00);
    wr(SSCR_CONTROL_OFS, 32'h00000001);
    waitRun(n);
    chk32(n, SSCR_RST_OP_CYC);
  endtask : fundWithStrap
  initial begin
    powerUp();
    statusWrite();
    controlWrite();
    hotWithLoad();
    fundWithStrap();
    end_sim();
  end
endmodule : switch_status_control_regs_test
